// File: inc/mbg_pkg.sv
package mbg_pkg;
	// clock and time base
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          MS_PER_S      = 1000;
	localparam int          CYC_PER_MS    = CLK_HZ / MS_PER_S;
	// selectable bit rates, codes 00..11 in ascending order
	localparam int          BAUD_R0       = 9600;
	localparam int          BAUD_R1       = 19200;
	localparam int          BAUD_R2       = 57600;
	localparam int          BAUD_R3       = 115200;
	// node addresses
	localparam logic [7:0]  ADDR_BCAST    = 8'h00;
	localparam logic [7:0]  ADDR_RSV_LO   = 8'hf8;
	// function and exception codes
	localparam logic [7:0]  FN_READ       = 8'h03;
	localparam logic [7:0]  FN_WRITE      = 8'h06;
	localparam logic [7:0]  FN_DIAG       = 8'h08;
	localparam logic [7:0]  FN_GW         = 8'h41;
	localparam logic [7:0]  FN_ERR_BIT    = 8'h80;
	localparam logic [7:0]  EXC_NONE      = 8'h00;
	localparam logic [7:0]  EXC_FUNC      = 8'h01;
	localparam logic [7:0]  EXC_DATA      = 8'h03;
	localparam logic [7:0]  EXC_DS        = 8'h0b;
	// ascii characters
	localparam logic [7:0]  CH_ZERO       = 8'h30;
	localparam logic [7:0]  CH_NINE       = 8'h39;
	localparam logic [7:0]  CH_A          = 8'h41;
	localparam logic [7:0]  CH_F          = 8'h46;
	localparam logic [7:0]  CH_CR         = 8'h0d;
	localparam logic [7:0]  CH_LF         = 8'h0a;
	localparam logic [7:0]  HEX_A_VAL     = 8'h0a;
	// frame buffer: address, function, two address bytes, two value bytes
	localparam logic [2:0]  FRAME_BYTES   = 3'h6;
	localparam logic [2:0]  MIN_BYTES     = 3'h2;
	// off-line timer
	localparam logic [15:0] TIMER_RST_MS  = 16'h00c8;
	localparam logic [15:0] TIMER_REG_DEF = 16'h0100;
	// register port
	localparam int          REG_AW        = 2;
	localparam logic [1:0]  REG_STATUS    = 2'h0;
	localparam logic [1:0]  REG_TIMER     = 2'h1;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_RECV    = 3'b001,
		ST_EXEC    = 3'b010,
		ST_MEMRD   = 3'b011,
		ST_WAIT_DS = 3'b100,
		ST_RESP    = 3'b101
	} mbg_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10,
		RX_STOP  = 2'b11
	} mbg_rx_t;
endpackage

// File: verilog/mbg_param_mem.sv
`timescale 1ns/100ps
`default_nettype none
module mbg_param_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
)(
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    addr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	output logic      [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	// image contents are volatile and need no reset
	always_ff @(posedge clock_i)
	begin
		if (we_i)
			mem[addr_i] <= wdata_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
			rdata_o <= '0;
		else
			rdata_o <= mem[addr_i];
	end
endmodule
`default_nettype wire

// File: verilog/mbg_char_rx.sv
`timescale 1ns/100ps
`default_nettype none
module mbg_char_rx #(
	parameter int CLK_HZ = mbg_pkg::CLK_HZ,
	parameter int BAUD_0 = mbg_pkg::BAUD_R0,
	parameter int BAUD_1 = mbg_pkg::BAUD_R1,
	parameter int BAUD_2 = mbg_pkg::BAUD_R2,
	parameter int BAUD_3 = mbg_pkg::BAUD_R3
)(
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       rx_i,
	input  wire logic       abort_i,
	input  wire logic       seven_bit_i,
	input  wire logic       no_parity_i,
	input  wire logic [1:0] baud_sel_i,
	output logic            char_valid_o,
	output logic      [7:0] char_data_o,
	output logic            char_ok_o
);
	import mbg_pkg::*;
	mbg_rx_t     st_reg, st_next;
	logic [15:0] cnt_reg, cnt_next, div;
	logic [3:0]  idx_reg, idx_next, nbits;
	logic [8:0]  sh_reg, sh_next;
	logic        vld_next, ok_next, par;
	logic [7:0]  dat_next;

	always_comb
	begin
		unique case (baud_sel_i)
			2'b00: div = 16'(CLK_HZ / BAUD_0);
			2'b01: div = 16'(CLK_HZ / BAUD_1);
			2'b10: div = 16'(CLK_HZ / BAUD_2);
			2'b11: div = 16'(CLK_HZ / BAUD_3);
		endcase
		// data bits plus the parity or second stop slot
		nbits = seven_bit_i ? 4'h8 : 4'h9;
		st_next = st_reg;
		cnt_next = (cnt_reg == '0) ? cnt_reg : cnt_reg - 16'h0001;
		idx_next = idx_reg;
		sh_next = sh_reg;
		vld_next = 1'b0;
		dat_next = seven_bit_i ? {1'b0, sh_reg[7:1]} : sh_reg[7:0];
		par = sh_reg[8];
		ok_next = rx_i && (no_parity_i ? par : (par == ^dat_next));
		unique case (st_reg)
			RX_IDLE:
				if (!rx_i)
				begin
					st_next = RX_START;
					cnt_next = {1'b0, div[15:1]};
				end
			RX_START:
				if (cnt_reg == '0)
				begin
					st_next = rx_i ? RX_IDLE : RX_BITS;
					// reload one short: the zero count is a cycle of its own
					cnt_next = div - 16'h0001;
					idx_next = '0;
				end
			RX_BITS:
				if (cnt_reg == '0)
				begin
					sh_next = {rx_i, sh_reg[8:1]};   // lsb first
					idx_next = idx_reg + 4'h1;
					cnt_next = div - 16'h0001;
					if (idx_reg == nbits - 4'h1)
						st_next = RX_STOP;
				end
			RX_STOP:
				if (cnt_reg == '0)
				begin
					vld_next = 1'b1;
					st_next = RX_IDLE;
				end
		endcase
		if (abort_i)
		begin
			st_next = RX_IDLE;
			vld_next = 1'b0;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			st_reg <= RX_IDLE;
			cnt_reg <= '0;
			idx_reg <= '0;
			sh_reg <= '0;
			char_valid_o <= 1'b0;
			char_data_o <= '0;
			char_ok_o <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			sh_reg <= sh_next;
			char_valid_o <= vld_next;
			if (vld_next)
			begin
				char_data_o <= dat_next;
				char_ok_o <= ok_next;
			end
		end
	end
endmodule
`default_nettype wire

// File: verilog/mbg_gateway.sv
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - node address from eight switches, first switch is msb, on reads one.
// - node address 0 or 248..255 disables frame handling; the register port stays live.
// - serve addresses 1..247; process frames only for our own address or broadcast address 0.
// - a switch change aborts the transaction first, then applies settings.
// - parity switch off: even parity over data bits; bad parity, no reply.
// - parity switch on: slot is second stop; a zero there means no reply.
// - mode switch off selects RTU, on selects ASCII.
// - two baud switches select 9600, 19200, 57600 or 115200.
// - accept functions 03, 06, 08, 41; others give an error reply.
// - function 41 enters gateway mode and forwards to the controller.
// - functions 03 and 06 enter register mode using the local image.
// - after reset the unit is in register mode.
// - function 08 is a local diagnostic and keeps the mode.
// - downstream exchanges timed by off-line timer, 200 ms at reset; 0B on expiry.
// - timer written by function 06, read by 03, volatile.
// - gateway answer within timer; first timeout late, then 0B at once.
// - 03 and 06 answer at once, 0B while faulted; 08 never 0B.
// - RTU character: start, 8 data lsb first, parity or stop, stop.
// - ASCII character: start, 7 data lsb first, parity or stop, stop.
// - error reply: function with top bit set plus exception 01, 03 or 0B.
// - address 0 is broadcast: executed, never answered.
module mbg_gateway #(
	parameter int          CYCLES_PER_MS  = mbg_pkg::CYC_PER_MS,
	parameter logic [15:0] TIMER_REG_ADDR = mbg_pkg::TIMER_REG_DEF,
	parameter int          IMG_DEPTH      = 16,
	parameter int          BAUD_0         = mbg_pkg::BAUD_R0,
	parameter int          BAUD_1         = mbg_pkg::BAUD_R1,
	parameter int          BAUD_2         = mbg_pkg::BAUD_R2,
	parameter int          BAUD_3         = mbg_pkg::BAUD_R3
)(
	input  wire logic                       clock_i,
	input  wire logic                       rstn_i,
	input  wire logic [7:0]                 address_switch_bank_i,
	input  wire logic                       parity_select_switch_i,
	input  wire logic                       framing_mode_switch_i,
	input  wire logic                       baud_select_hi_i,
	input  wire logic                       baud_select_lo_i,
	input  wire logic                       rx_i,
	input  wire logic                       frame_start_i,
	input  wire logic                       frame_end_i,
	input  wire logic                       frame_check_ok_i,
	output logic                            resp_valid_o,
	output logic [7:0]                      resp_func_o,
	output logic [7:0]                      resp_exc_o,
	output logic [15:0]                     resp_data_o,
	output logic                            ds_req_o,
	output logic [31:0]                     ds_req_data_o,
	input  wire logic                       ds_reply_i,
	input  wire logic                       ds_error_i,
	input  wire logic [15:0]                ds_reply_data_i,
	input  wire logic                       ds_recovered_i,
	input  wire logic [mbg_pkg::REG_AW-1:0] reg_addr_i,
	input  wire logic [15:0]                reg_wdata_i,
	input  wire logic                       reg_we_i,
	input  wire logic                       reg_re_i,
	output logic [15:0]                     reg_rdata_o
);
	import mbg_pkg::*;
	localparam int          IMG_AW = $clog2(IMG_DEPTH);
	localparam logic [15:0] IMG_DW = 16'(IMG_DEPTH);
	localparam int          TICK_W = $clog2(CYCLES_PER_MS + 1);

	// switches and the serial line are asynchronous pins
	logic [11:0] sw_meta_reg, sw_sync_reg, sw_live_reg;
	logic        rx_meta_reg, rx_sync_reg;
	logic [7:0]  node;
	logic        no_parity, ascii, cfg_change, disabled;

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			sw_meta_reg <= '0;
			sw_sync_reg <= '0;
			sw_live_reg <= '0;
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end
		else
		begin
			sw_meta_reg <= {address_switch_bank_i, parity_select_switch_i,
				framing_mode_switch_i, baud_select_hi_i, baud_select_lo_i};
			sw_sync_reg <= sw_meta_reg;
			sw_live_reg <= sw_sync_reg;
			rx_meta_reg <= rx_i;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	// the change cycle aborts; the new values become live one edge later
	assign cfg_change = sw_sync_reg != sw_live_reg;
	assign node = sw_live_reg[11:4];
	assign no_parity = sw_live_reg[3];
	assign ascii = sw_live_reg[2];
	assign disabled = (node == ADDR_BCAST) || (node >= ADDR_RSV_LO);

	logic       char_valid, char_ok;
	logic [7:0] char_data;

	mbg_char_rx #(
		.CLK_HZ (CLK_HZ),
		.BAUD_0 (BAUD_0),
		.BAUD_1 (BAUD_1),
		.BAUD_2 (BAUD_2),
		.BAUD_3 (BAUD_3)
	) u_rx (
		.clock_i      (clock_i),
		.rstn_i       (rstn_i),
		.rx_i         (rx_sync_reg),
		.abort_i      (cfg_change),
		.seven_bit_i  (ascii),
		.no_parity_i  (no_parity),
		.baud_sel_i   (sw_live_reg[1:0]),
		.char_valid_o (char_valid),
		.char_data_o  (char_data),
		.char_ok_o    (char_ok)
	);

	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= CH_ZERO && c <= CH_NINE)
			return {1'b1, 4'(c - CH_ZERO)};
		else if (c >= CH_A && c <= CH_F)
			return {1'b1, 4'(c - CH_A + HEX_A_VAL)};
		else
			return 5'h00;
	endfunction

	mbg_state_t  state_reg, state_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic        bad_reg, bad_next, half_reg, half_next, bcast_reg, bcast_next;
	logic [3:0]  nib_reg, nib_next;
	logic [7:0]  buf_reg [6];
	logic [7:0]  buf_next [6];
	logic        gw_reg, gw_next, fault_reg, fault_next, req_reg, req_next;
	logic [7:0]  func_reg, func_next, exc_reg, exc_next;
	logic [15:0] data_reg, data_next, timer_reg, timer_next;
	logic [15:0] reg_a, val, mem_rdata;
	logic [7:0]  fn, byte_val;
	logic [4:0]  hv;
	logic        byte_ok, mem_we, load_wait, expired;

	assign fn = buf_reg[1];
	assign reg_a = {buf_reg[2], buf_reg[3]};
	assign val = {buf_reg[4], buf_reg[5]};

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		bad_next = bad_reg;
		half_next = half_reg;
		nib_next = nib_reg;
		buf_next = buf_reg;
		bcast_next = bcast_reg;
		gw_next = gw_reg;
		fault_next = fault_reg;
		req_next = req_reg;
		func_next = func_reg;
		exc_next = exc_reg;
		data_next = data_reg;
		timer_next = timer_reg;
		mem_we = 1'b0;
		load_wait = 1'b0;
		byte_ok = 1'b0;
		byte_val = char_data;
		hv = hex_val(char_data);
		if (char_valid && state_reg == ST_RECV)
		begin
			if (!char_ok)
				bad_next = 1'b1;
			if (!ascii)
				byte_ok = 1'b1;
			else if (char_data != CH_CR && char_data != CH_LF)
			begin
				// two hex characters make one byte, high nibble first
				if (!hv[4])
					bad_next = 1'b1;
				else if (!half_reg)
				begin
					nib_next = hv[3:0];
					half_next = 1'b1;
				end
				else
				begin
					byte_ok = 1'b1;
					byte_val = {nib_reg, hv[3:0]};
					half_next = 1'b0;
				end
			end
		end
		// bytes past the fixed request fields are not needed and dropped
		if (byte_ok && cnt_reg < FRAME_BYTES)
		begin
			buf_next[cnt_reg] = byte_val;
			cnt_next = cnt_reg + 3'h1;
		end
		if (reg_we_i && reg_addr_i == REG_TIMER)
			timer_next = reg_wdata_i;
		if (ds_recovered_i)
			fault_next = 1'b0;
		unique case (state_reg)
			ST_IDLE:
				if (frame_start_i && !disabled)
				begin
					state_next = ST_RECV;
					cnt_next = '0;
					bad_next = 1'b0;
					half_next = 1'b0;
				end
			ST_RECV:
				if (frame_end_i)
				begin
					if (bad_next || !frame_check_ok_i || cnt_next < MIN_BYTES)
						state_next = ST_IDLE;
					else if (buf_next[0] != node && buf_next[0] != ADDR_BCAST)
						state_next = ST_IDLE;
					else
					begin
						state_next = ST_EXEC;
						bcast_next = buf_next[0] == ADDR_BCAST;
					end
				end
			ST_EXEC:
			begin
				func_next = fn;
				exc_next = EXC_NONE;
				data_next = '0;
				state_next = ST_RESP;
				if (fn == FN_DIAG)
					data_next = val;
				else if (fn == FN_READ || fn == FN_WRITE)
				begin
					gw_next = 1'b0;
					if (fault_reg)
						exc_next = EXC_DS;
					else if (cnt_reg < FRAME_BYTES)
						exc_next = EXC_DATA;
					else if (reg_a == TIMER_REG_ADDR)
					begin
						if (fn == FN_WRITE)
							timer_next = val;
						data_next = (fn == FN_WRITE) ? val : timer_reg;
					end
					else if (reg_a < IMG_DW)
					begin
						mem_we = fn == FN_WRITE;
						data_next = val;
						if (fn == FN_READ)
							state_next = ST_MEMRD;
					end
					else
						exc_next = EXC_DATA;
				end
				else if (fn == FN_GW)
				begin
					gw_next = 1'b1;
					if (fault_reg)
						exc_next = EXC_DS;
					else
					begin
						req_next = 1'b1;
						load_wait = 1'b1;
						state_next = ST_WAIT_DS;
					end
				end
				else
					exc_next = EXC_FUNC;
			end
			ST_MEMRD:
			begin
				data_next = mem_rdata;
				state_next = ST_RESP;
			end
			ST_WAIT_DS:
				if (ds_reply_i)
				begin
					req_next = 1'b0;
					data_next = ds_reply_data_i;
					state_next = ST_RESP;
					if (ds_error_i)
					begin
						exc_next = EXC_DS;
						fault_next = 1'b1;
					end
				end
				else if (expired)
				begin
					req_next = 1'b0;
					exc_next = EXC_DS;
					fault_next = 1'b1;
					state_next = ST_RESP;
				end
			ST_RESP:
				state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
		if (cfg_change || (disabled && state_reg != ST_IDLE))
		begin
			state_next = ST_IDLE;
			req_next = 1'b0;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			bad_reg <= 1'b0;
			half_reg <= 1'b0;
			nib_reg <= '0;
			buf_reg <= '{default: 8'h00};
			bcast_reg <= 1'b0;
			gw_reg <= 1'b0;
			fault_reg <= 1'b0;
			req_reg <= 1'b0;
			func_reg <= '0;
			exc_reg <= EXC_NONE;
			data_reg <= '0;
			timer_reg <= TIMER_RST_MS;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bad_reg <= bad_next;
			half_reg <= half_next;
			nib_reg <= nib_next;
			buf_reg <= buf_next;
			bcast_reg <= bcast_next;
			gw_reg <= gw_next;
			fault_reg <= fault_next;
			req_reg <= req_next;
			func_reg <= func_next;
			exc_reg <= exc_next;
			data_reg <= data_next;
			timer_reg <= timer_next;
		end
	end

	mbg_param_mem #(
		.WIDTH (16),
		.DEPTH (IMG_DEPTH)
	) u_img (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.we_i    (mem_we),
		.addr_i  (reg_a[IMG_AW-1:0]),
		.wdata_i (val),
		.rdata_o (mem_rdata)
	);

	// off-line timer: millisecond prescaler and remaining count
	logic [TICK_W-1:0] tick_reg, tick_next;
	logic [15:0]       left_reg, left_next, rdata_next;

	always_comb
	begin
		tick_next = tick_reg;
		left_next = left_reg;
		expired = 1'b0;
		if (load_wait)
		begin
			tick_next = '0;
			left_next = timer_reg;
		end
		else if (state_reg == ST_WAIT_DS)
		begin
			if (left_reg == '0)
				expired = 1'b1;
			else if (tick_reg == TICK_W'(CYCLES_PER_MS - 1))
			begin
				tick_next = '0;
				left_next = left_reg - 16'h0001;
			end
			else
				tick_next = tick_reg + 1'b1;
		end
		rdata_next = '0;
		if (reg_re_i && reg_addr_i == REG_STATUS)
			rdata_next = {node, 4'h0, req_reg, disabled, fault_reg, gw_reg};
		else if (reg_re_i && reg_addr_i == REG_TIMER)
			rdata_next = timer_reg;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			tick_reg <= '0;
			left_reg <= '0;
			reg_rdata_o <= '0;
		end
		else
		begin
			tick_reg <= tick_next;
			left_reg <= left_next;
			reg_rdata_o <= rdata_next;
		end
	end

	assign resp_valid_o = state_reg == ST_RESP && !bcast_reg;
	assign resp_func_o = (exc_reg != EXC_NONE) ? (func_reg | FN_ERR_BIT) : func_reg;
	assign resp_exc_o = exc_reg;
	assign resp_data_o = data_reg;
	assign ds_req_o = req_reg;
	assign ds_req_data_o = {buf_reg[2], buf_reg[3], buf_reg[4], buf_reg[5]};

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	a_disabled_idle: assert property (disabled |=> state_reg == ST_IDLE)
		else $error("disabled unit left idle");
	a_addr_filter: assert property (state_reg == ST_RECV && frame_end_i
		&& !bad_next && frame_check_ok_i && cnt_next >= MIN_BYTES
		&& buf_next[0] != node && buf_next[0] != ADDR_BCAST |=> state_reg == ST_IDLE)
		else $error("foreign address processed");
	a_cfg_abort: assert property (cfg_change |=> state_reg == ST_IDLE && !ds_req_o)
		else $error("switch change did not abort");
	a_bad_char: assert property (state_reg == ST_RECV && char_valid && !char_ok
		|=> bad_reg || state_reg == ST_IDLE)
		else $error("bad character not flagged");
	a_bad_quiet: assert property (bad_reg && state_reg == ST_RECV && frame_end_i
		|=> state_reg == ST_IDLE ##1 !resp_valid_o)
		else $error("bad frame answered");
	a_unsupported: assert property (state_reg == ST_EXEC && fn != FN_READ
		&& fn != FN_WRITE && fn != FN_DIAG && fn != FN_GW && !cfg_change
		|=> resp_exc_o == EXC_FUNC && resp_func_o[7])
		else $error("unsupported function not refused");
	a_gw_enter: assert property (state_reg == ST_EXEC && fn == FN_GW |=> gw_reg)
		else $error("gateway mode not entered");
	a_reg_mode: assert property (state_reg == ST_EXEC
		&& (fn == FN_READ || fn == FN_WRITE) |=> !gw_reg)
		else $error("register mode not entered");
	a_reset_mode: assert property ($rose(rstn_i) |-> !gw_reg)
		else $error("not in register mode after reset");
	a_diag_keep: assert property (state_reg == ST_EXEC && fn == FN_DIAG
		|=> $stable(gw_reg) && resp_exc_o != EXC_DS)
		else $error("diagnostic disturbed mode");
	a_timeout: assert property (state_reg == ST_WAIT_DS && expired && !ds_reply_i
		&& !cfg_change && !disabled |=> state_reg == ST_RESP && resp_exc_o == EXC_DS
		&& fault_reg)
		else $error("timeout not reported");
	a_fault_fast: assert property (state_reg == ST_EXEC && fault_reg && !cfg_change
		&& (fn == FN_READ || fn == FN_WRITE || fn == FN_GW)
		|=> state_reg == ST_RESP && resp_exc_o == EXC_DS)
		else $error("faulted request not answered at once");
	a_bcast_quiet: assert property (resp_valid_o |-> buf_reg[0] == node && |buf_reg[0])
		else $error("broadcast answered");

	c_gw_timeout: cover property (state_reg == ST_WAIT_DS && expired);
	c_gw_reply: cover property (state_reg == ST_WAIT_DS && ds_reply_i && !ds_error_i);
	c_mem_read: cover property (state_reg == ST_MEMRD ##1 resp_valid_o);
	c_broadcast: cover property (state_reg == ST_RESP && bcast_reg);
endmodule
`default_nettype wire

// File: tb/mbg_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module mbg_master_model #(
	parameter int BIT_CYC = 10
)(
	input  wire logic clock_i,
	input  wire logic no_parity_i,
	input  wire logic ascii_i,
	input  wire logic slow_i,
	output logic      rx_o,
	output logic      frame_start_o,
	output logic      frame_end_o,
	output logic      check_ok_o
);
	initial
	begin
		rx_o = 1'b1;
		frame_start_o = 1'b0;
		frame_end_o = 1'b0;
		check_ok_o = 1'b1;
	end

	// bad flips the parity bit, or puts a zero in the second stop slot
	function automatic logic [7:0] hex_ch(input logic [3:0] v);
		return (v > 4'h9) ? 8'h37 + 8'(v) : 8'h30 + 8'(v);
	endfunction

	// an ascii character is followed by one extra idle bit to keep one loop
	task automatic send_char(input logic [7:0] b, input logic bad);
		logic [10:0] f;
		logic        p;
		p = no_parity_i ? ~bad : ^b ^ bad;
		f = ascii_i ? {2'b11, p, b[6:0], 1'b0} : {1'b1, p, b, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			rx_o <= f[i];
			repeat (slow_i ? 2 * BIT_CYC : BIT_CYC) @(posedge clock_i);
		end
	endtask

	task automatic send_frame(input logic [47:0] fr, input int bad);
		@(posedge clock_i);
		frame_start_o <= 1'b1;
		@(posedge clock_i);
		frame_start_o <= 1'b0;
		for (int i = 0; i < (ascii_i ? 12 : 6); i++)
			if (ascii_i)
				send_char(hex_ch(fr[47-4*i -: 4]), i == 2 * bad);
			else
				send_char(fr[47-8*i -: 8], i == bad);
		// line idles high after the last stop bit
		repeat (4) @(posedge clock_i);
		frame_end_o <= 1'b1;
		@(posedge clock_i);
		frame_end_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_modbus_serial_slave_gateway.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin n_fail++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tb_modbus_serial_slave_gateway;
	import mbg_pkg::*;
	typedef struct packed {
		logic [7:0]  sw;
		logic        par;
		logic [3:0]  bad;
		logic [47:0] fr;
		logic        er;
		logic [7:0]  ef;
		logic [7:0]  ee;
		logic [15:0] ed;
	} mbg_row_t;
	localparam mbg_row_t ROWS [12] = '{
		'{8'h11, 1'b0, 4'hf, 48'h110601000005, 1'b1, 8'h06, 8'h00, 16'h0005},
		'{8'h11, 1'b0, 4'hf, 48'h110301000001, 1'b1, 8'h03, 8'h00, 16'h0005},
		'{8'h11, 1'b0, 4'hf, 48'h110800001234, 1'b1, 8'h08, 8'h00, 16'h1234},
		'{8'h11, 1'b0, 4'hf, 48'h110700000000, 1'b1, 8'h87, 8'h01, 16'h0000},
		'{8'h11, 1'b0, 4'hf, 48'h110300200001, 1'b1, 8'h83, 8'h03, 16'h0000},
		'{8'h11, 1'b0, 4'h2, 48'h110800001234, 1'b0, 8'h00, 8'h00, 16'h0000},
		'{8'h11, 1'b0, 4'hf, 48'h120800001234, 1'b0, 8'h00, 8'h00, 16'h0000},
		'{8'h11, 1'b0, 4'hf, 48'h0006000500aa, 1'b0, 8'h00, 8'h00, 16'h0000},
		'{8'h11, 1'b0, 4'hf, 48'h110300050001, 1'b1, 8'h03, 8'h00, 16'h00aa},
		'{8'h11, 1'b1, 4'hf, 48'h11080000beef, 1'b1, 8'h08, 8'h00, 16'hbeef},
		'{8'h11, 1'b1, 4'h3, 48'h11080000beef, 1'b0, 8'h00, 8'h00, 16'h0000},
		'{8'hf8, 1'b0, 4'hf, 48'hf80800000000, 1'b0, 8'h00, 8'h00, 16'h0000}
	};
	logic        clock_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [7:0]  addr_sw = 8'h11;
	logic        par_sw = 1'b0;
	logic        ascii_sw = 1'b0, baud_lo = 1'b1;
	logic        rx, fs, fe, fok, resp_valid_o, ds_req_o;
	logic [7:0]  resp_func_o, resp_exc_o;
	logic [15:0] resp_data_o, reg_rdata_o, ds_data = 16'h0000, reg_wdata_i = 16'h0000;
	logic [31:0] ds_req_data_o;
	logic        ds_reply = 1'b0, ds_err = 1'b0, ds_rec = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
	logic [1:0]  reg_addr_i = 2'h0;
	int          n_fail = 0, compares = 0, n;

	always #5 clock_i = ~clock_i;

	// bit rate raised so a frame costs hundreds of cycles, not tens of thousands
	mbg_gateway #(.CYCLES_PER_MS(10), .BAUD_2(5_000_000), .BAUD_3(10_000_000)) mbg_gateway_inst (
		.clock_i(clock_i), .rstn_i(rstn_i), .address_switch_bank_i(addr_sw),
		.parity_select_switch_i(par_sw), .framing_mode_switch_i(ascii_sw),
		.baud_select_hi_i(1'b1), .baud_select_lo_i(baud_lo), .rx_i(rx),
		.frame_start_i(fs), .frame_end_i(fe), .frame_check_ok_i(fok),
		.resp_valid_o(resp_valid_o), .resp_func_o(resp_func_o), .resp_exc_o(resp_exc_o),
		.resp_data_o(resp_data_o), .ds_req_o(ds_req_o), .ds_req_data_o(ds_req_data_o),
		.ds_reply_i(ds_reply), .ds_error_i(ds_err), .ds_reply_data_i(ds_data),
		.ds_recovered_i(ds_rec), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));

	mbg_master_model #(.BIT_CYC(10)) master_inst (
		.clock_i(clock_i), .no_parity_i(par_sw), .rx_o(rx),
		.ascii_i(ascii_sw), .slow_i(!baud_lo),
		.frame_start_o(fs), .frame_end_o(fe), .check_ok_o(fok));

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clock_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, input logic [15:0] ex);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clock_i);
		reg_re_i <= 1'b0;
		#1;
		`CHK("reg_rdata", ex, reg_rdata_o)
	endtask

	task automatic run(input logic [47:0] fr, input int bad, input logic er,
		input logic [7:0] ef, input logic [7:0] ee, input logic [15:0] ed);
		master_inst.send_frame(fr, bad);
		n = 0;
		while (n < 90 && resp_valid_o !== 1'b1)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		`CHK("resp_valid", er, resp_valid_o === 1'b1)
		if (er)
		begin
			`CHK("resp_func", ef, resp_func_o)
			`CHK("resp_exc", ee, resp_exc_o)
			if (ee == 8'h00)
				`CHK("resp_data", ed, resp_data_o)
		end
	endtask

	initial
	begin
		#500000;
		n_fail++;
		close_out();
	end

	initial
	begin
		repeat (8) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		rd(2'h0, 16'h1100);
		rd(2'h1, 16'h00c8);
		rd(2'h2, 16'h0000);
		foreach (ROWS[i])
		begin
			@(posedge clock_i);
			addr_sw <= ROWS[i].sw;
			par_sw <= ROWS[i].par;
			repeat (8) @(posedge clock_i);
			run(ROWS[i].fr, ROWS[i].bad, ROWS[i].er, ROWS[i].ef, ROWS[i].ee, ROWS[i].ed);
		end
		@(posedge clock_i);
		addr_sw <= 8'h11;
		par_sw <= 1'b0;
		repeat (8) @(posedge clock_i);
		master_inst.send_frame(48'h114100010002, 15);
		repeat (3) @(posedge clock_i);
		ds_reply <= 1'b1;
		ds_data <= 16'h4321;
		#1;
		`CHK("ds_req_data", 32'h00010002, ds_req_data_o)
		@(posedge clock_i);
		ds_reply <= 1'b0;
		#1;
		`CHK("gw_resp", 33'h141004321, {resp_valid_o, resp_func_o, resp_exc_o, resp_data_o})
		rd(2'h0, 16'h1101);
		run(48'h110800000001, 15, 1'b1, 8'h08, 8'h00, 16'h0001);
		rd(2'h0, 16'h1101);
		master_inst.send_frame(48'h114100010002, 15);
		repeat (3) @(posedge clock_i);
		addr_sw <= 8'h12;
		repeat (8) @(posedge clock_i);
		#1;
		`CHK("ds_req_abort", 1'b0, ds_req_o)
		@(posedge clock_i);
		addr_sw <= 8'h11;
		repeat (8) @(posedge clock_i);
		run(48'h114100010002, 15, 1'b1, 8'hc1, 8'h0b, 16'h0000);
		`CHK("late_timeout", 1'b1, n > 49 && n < 62)
		run(48'h114100010002, 15, 1'b1, 8'hc1, 8'h0b, 16'h0000);
		`CHK("fast_fault", 1'b1, n < 5)
		run(48'h110301000001, 15, 1'b1, 8'h83, 8'h0b, 16'h0000);
		run(48'h110800005a5a, 15, 1'b1, 8'h08, 8'h00, 16'h5a5a);
		@(posedge clock_i);
		ds_rec <= 1'b1;
		@(posedge clock_i);
		ds_rec <= 1'b0;
		run(48'h110301000001, 15, 1'b1, 8'h03, 8'h00, 16'h0005);
		master_inst.send_frame(48'h114100010002, 15);
		@(posedge clock_i);
		ds_reply <= 1'b1;
		ds_err <= 1'b1;
		@(posedge clock_i);
		ds_reply <= 1'b0;
		ds_err <= 1'b0;
		#1;
		`CHK("ds_err_resp", 17'h1c10b, {resp_valid_o, resp_func_o, resp_exc_o})
		// a second reset must drop the written timer, the fault and gateway mode
		@(posedge clock_i);
		rstn_i <= 1'b0;
		ascii_sw <= 1'b1;
		baud_lo <= 1'b0;
		repeat (8) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		rd(2'h0, 16'h1100);
		rd(2'h1, 16'h00c8);
		wr(2'h1, 16'h0014);
		rd(2'h1, 16'h0014);
		run(48'h11080000c3a5, 15, 1'b1, 8'h08, 8'h00, 16'hc3a5);
		run(48'h11080000c3a5, 4, 1'b0, 8'h00, 8'h00, 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
